// ==== rmc_consts.svh ====
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH
// register offsets
`define RMC_OFS_CMP_A      8'hdd
`define RMC_OFS_CMP_B      8'hde
`define RMC_OFS_FMASK_LO   8'he5
`define RMC_OFS_FMASK_HI   8'he6
`define RMC_OFS_PG_LO      8'he7
`define RMC_OFS_PG_HI      8'he8
`define RMC_OFS_MISC       8'he9
// reset values
`define RMC_RST_CMP_A      8'hb6
`define RMC_RST_CMP_B      8'h1b
`define RMC_RST_FMASK_LO   8'h01
`define RMC_RST_FMASK_HI   2'h0
`define RMC_RST_MISC       8'h02
// reserved read-back fill
`define RMC_FMASK_HI_FILL  6'h3f
`define RMC_PG_HI_FILL     3'h7
// comparator field positions
`define RMC_CMP_MODE_BIT   7
`define RMC_CMP_SHIFT_MSB  6
`define RMC_CMP_SHIFT_LSB  3
`define RMC_CMP_LEVEL_MSB  2
`define RMC_CMP_LEVEL_LSB  0
`define RMC_LEVEL_1V0      3'h0
`endif

// ==== rmc_pkg.sv ====
package rmc_pkg;
	// comparator reference register layout
	typedef struct packed {
		logic       function_select; // 1 = plain comparator
		logic [3:0] window_shift;
		logic [2:0] window_level;
	} rmc_cmp_ref_t;

	// miscellaneous control register layout
	typedef struct packed {
		logic termination_enable_override;
		logic termination_enable_mask;
		logic precharge_enable_override;
		logic precharge_enable_mask;
		logic s3_sleep_tree_mask;
		logic suspend_sleep_tree_mask;
		logic shifter_adapter_route;
		logic termination_discharge_enable;
	} rmc_misc_t;

	// register access port from the serial-bus front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rmc_req_t;

	// whole state of the bank
	typedef struct packed {
		rmc_cmp_ref_t cmp_a;
		rmc_cmp_ref_t cmp_b;
		logic [7:0]   fmask_lo;
		logic [1:0]   fmask_hi;
		rmc_misc_t    misc;
		logic [7:0]   rdata;
		logic         rvalid;
		logic [9:0]   fault;
	} rmc_state_t;
endpackage

// ==== rmc_regs.sv ====
`timescale 1ns/1ps
`include "rmc_consts.svh"
module rmc_regs (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire rmc_pkg::rmc_req_t req,
	output logic [7:0]            rdata,
	output logic                  rvalid,
	input  wire logic [7:0]       pg_low_in,
	input  wire logic [4:0]       pg_high_in,
	input  wire logic             memory_termination_control_pin,
	input  wire logic             switched_3v3_pin,
	input  wire logic             switched_3v3_pin_mask,
	input  wire logic             precharge_enable_pin,
	input  wire logic             regulator_enable_bit,
	input  wire logic             s3_sleep_signal,
	input  wire logic             suspend_sleep_signal,
	input  wire logic             adapter_ok_input,
	input  wire logic             level_shifter_in,
	output rmc_pkg::rmc_cmp_ref_t cmp_a_cfg,
	output rmc_pkg::rmc_cmp_ref_t cmp_b_cfg,
	output logic                  cmp_a_alt_level,
	output logic                  cmp_b_alt_level,
	output logic                  termination_enable,
	output logic                  switched_3v3_enable,
	output logic                  precharge_enable,
	output logic                  s3_sleep_tree_in,
	output logic                  suspend_sleep_tree_in,
	output logic                  level_shifter_out,
	output logic                  termination_discharge_enable,
	output logic [9:0]            power_fault
);

	rmc_pkg::rmc_state_t s_q;
	rmc_pkg::rmc_state_t s_d;
	logic [9:0]          unmasked_fail;

	////////////////////////////////////////////////////////////////////
	// fault sources: rail power-good input low, minus its mask bit
	// order: {core, 1v05, fmask_lo[7:0]} matching mask bit order
	always_comb begin
		unmasked_fail = ~{pg_low_in[1], pg_high_in[3],
			pg_low_in[0], pg_high_in[4], pg_low_in[2],
			pg_low_in[3], pg_low_in[4], pg_low_in[5],
			pg_low_in[6], pg_low_in[7]}
			& ~{s_q.fmask_hi[0], s_q.fmask_hi[1], s_q.fmask_lo};
	end

	////////////////////////////////////////////////////////////////////
	// next-state: register writes and the registered read data
	always_comb begin
		s_d = s_q;
		s_d.rvalid = req.rd;
		s_d.fault = unmasked_fail;
		if (req.wr) begin
			case (req.addr)
				`RMC_OFS_CMP_A:    s_d.cmp_a = req.wdata;
				`RMC_OFS_CMP_B:    s_d.cmp_b = req.wdata;
				`RMC_OFS_FMASK_LO: s_d.fmask_lo = req.wdata;
				`RMC_OFS_FMASK_HI: s_d.fmask_hi = req.wdata[1:0];
				`RMC_OFS_MISC:     s_d.misc = req.wdata;
				default:           s_d.misc = s_q.misc; // status is read-only
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				`RMC_OFS_CMP_A:    s_d.rdata = s_q.cmp_a;
				`RMC_OFS_CMP_B:    s_d.rdata = s_q.cmp_b;
				`RMC_OFS_FMASK_LO: s_d.rdata = s_q.fmask_lo;
				`RMC_OFS_FMASK_HI: s_d.rdata = {`RMC_FMASK_HI_FILL,
					s_q.fmask_hi};
				`RMC_OFS_PG_LO:    s_d.rdata = pg_low_in;
				`RMC_OFS_PG_HI:    s_d.rdata = {`RMC_PG_HI_FILL,
					pg_high_in};
				`RMC_OFS_MISC:     s_d.rdata = s_q.misc;
				default:           s_d.rdata = 8'h00; // unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; reset values load only constants
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.cmp_a <= `RMC_RST_CMP_A;
			s_q.cmp_b <= `RMC_RST_CMP_B;
			s_q.fmask_lo <= `RMC_RST_FMASK_LO;
			s_q.fmask_hi <= `RMC_RST_FMASK_HI;
			s_q.misc <= `RMC_RST_MISC;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// comparator configuration; the analog side decodes level and shift
	assign cmp_a_cfg = s_q.cmp_a;
	assign cmp_b_cfg = s_q.cmp_b;
	// 1 V level turns the shift field into an alternate level select
	assign cmp_a_alt_level = (s_q.cmp_a.window_level == `RMC_LEVEL_1V0);
	assign cmp_b_alt_level = (s_q.cmp_b.window_level == `RMC_LEVEL_1V0);

	////////////////////////////////////////////////////////////////////
	// rail enables and tree masking; combinational so pins pass through
	assign termination_enable = s_q.misc.termination_enable_mask
		? s_q.misc.termination_enable_override
		: memory_termination_control_pin;
	assign switched_3v3_enable =
		(s_q.misc.precharge_enable_override && !switched_3v3_pin_mask)
		| switched_3v3_pin;
	assign precharge_enable = s_q.misc.precharge_enable_mask
		? regulator_enable_bit : precharge_enable_pin;
	assign s3_sleep_tree_in = s_q.misc.s3_sleep_tree_mask
		| s3_sleep_signal;
	assign suspend_sleep_tree_in = s_q.misc.suspend_sleep_tree_mask
		| suspend_sleep_signal;
	assign level_shifter_out = s_q.misc.shifter_adapter_route
		? adapter_ok_input
		: level_shifter_in;
	assign termination_discharge_enable =
		s_q.misc.termination_discharge_enable;
	assign power_fault = s_q.fault;
	assign rdata = s_q.rdata;
	assign rvalid = s_q.rvalid;

	////////////////////////////////////////////////////////////////////
	// checks
	property p_tt_mask;
		@(posedge clk) disable iff (!resetn)
		s_q.misc.termination_enable_mask |->
			termination_enable == s_q.misc.termination_enable_override;
	endproperty
	a_tt_mask: assert property (p_tt_mask) else $error("override ignored");

	property p_tt_pin;
		@(posedge clk) disable iff (!resetn)
		!s_q.misc.termination_enable_mask |->
			termination_enable == memory_termination_control_pin;
	endproperty
	a_tt_pin: assert property (p_tt_pin) else $error("pin not followed");

	sequence s_wr_fmask_hi;
		req.wr && req.addr == `RMC_OFS_FMASK_HI && !req.rd;
	endsequence
	sequence s_rd_fmask_hi;
		req.rd && req.addr == `RMC_OFS_FMASK_HI && !req.wr;
	endsequence
	property p_fmask_hi_ones;
		@(posedge clk) disable iff (!resetn)
		s_rd_fmask_hi |=> rvalid && rdata[7:2] == 6'h3f;
	endproperty
	a_fmask_hi_ones: assert property (p_fmask_hi_ones)
		else $error("reserved bits not ones");

	property p_fmask_hi_wr;
		@(posedge clk) disable iff (!resetn)
		s_wr_fmask_hi ##1 s_rd_fmask_hi |=>
			rdata[1:0] == $past(req.wdata[1:0], 2);
	endproperty
	a_fmask_hi_wr: assert property (p_fmask_hi_wr)
		else $error("mask high write lost");

	property p_pg_lo;
		@(posedge clk) disable iff (!resetn)
		req.rd && req.addr == `RMC_OFS_PG_LO |=>
			rdata == $past(pg_low_in);
	endproperty
	a_pg_lo: assert property (p_pg_lo) else $error("status not live");

	property p_pg_hi;
		@(posedge clk) disable iff (!resetn)
		req.rd && req.addr == `RMC_OFS_PG_HI |=>
			rdata == {3'h7, $past(pg_high_in)};
	endproperty
	a_pg_hi: assert property (p_pg_hi) else $error("status high wrong");

	property p_shifter;
		@(posedge clk) disable iff (!resetn)
		level_shifter_out == (s_q.misc.shifter_adapter_route
			? adapter_ok_input : level_shifter_in);
	endproperty
	a_shifter: assert property (p_shifter) else $error("shifter route");

	property p_fault_mask;
		@(posedge clk) disable iff (!resetn)
		s_q.fmask_lo[0] && $stable(s_q.fmask_lo[0]) |-> !power_fault[0];
	endproperty
	a_fault_mask: assert property (p_fault_mask)
		else $error("masked rail faulted");

	property p_s3;
		@(posedge clk) disable iff (!resetn)
		s_q.misc.s3_sleep_tree_mask |-> s3_sleep_tree_in;
	endproperty
	a_s3: assert property (p_s3) else $error("s3 not forced");

	property p_sus;
		@(posedge clk) disable iff (!resetn)
		s_q.misc.suspend_sleep_tree_mask |-> suspend_sleep_tree_in;
	endproperty
	a_sus: assert property (p_sus) else $error("suspend not forced");

	////////////////////////////////////////////////////////////////////
	// write landing: each strobe shows up one cycle later
	sequence s_wr_cmp_a;
		req.wr && req.addr == `RMC_OFS_CMP_A;
	endsequence
	sequence s_wr_cmp_b;
		req.wr && req.addr == `RMC_OFS_CMP_B;
	endsequence
	sequence s_wr_misc;
		req.wr && req.addr == `RMC_OFS_MISC;
	endsequence
	sequence s_wr_status;
		req.wr && (req.addr == `RMC_OFS_PG_LO
			|| req.addr == `RMC_OFS_PG_HI);
	endsequence

	property p_cmp_a_wr;
		@(posedge clk) disable iff (!resetn)
		s_wr_cmp_a |=> cmp_a_cfg == $past(req.wdata);
	endproperty
	a_cmp_a_wr: assert property (p_cmp_a_wr)
		else $error("cmp a write lost");

	property p_cmp_b_wr;
		@(posedge clk) disable iff (!resetn)
		s_wr_cmp_b |=> cmp_b_cfg == $past(req.wdata);
	endproperty
	a_cmp_b_wr: assert property (p_cmp_b_wr)
		else $error("cmp b write lost");

	property p_misc_wr;
		@(posedge clk) disable iff (!resetn)
		s_wr_misc |=> s_q.misc == $past(req.wdata);
	endproperty
	a_misc_wr: assert property (p_misc_wr)
		else $error("misc write lost");

	// status is read-only: a stray write must leave every setting alone
	property p_status_ro;
		@(posedge clk) disable iff (!resetn)
		s_wr_status |=> $stable({s_q.cmp_a, s_q.cmp_b, s_q.fmask_lo,
			s_q.fmask_hi, s_q.misc});
	endproperty
	a_status_ro: assert property (p_status_ro)
		else $error("status write changed state");

	////////////////////////////////////////////////////////////////////
	// read answer timing and unmapped reads
	property p_rvalid;
		@(posedge clk) disable iff (!resetn)
		req.rd |=> rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read not answered");

	property p_rvalid_idle;
		@(posedge clk) disable iff (!resetn)
		!req.rd |=> !rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle)
		else $error("spurious read answer");

	property p_unmapped;
		@(posedge clk) disable iff (!resetn)
		req.rd && req.addr == 8'h00 |=> rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	////////////////////////////////////////////////////////////////////
	// alternate level flag tracks the 1 V window code
	property p_alt_a;
		@(posedge clk) disable iff (!resetn)
		cmp_a_alt_level == (cmp_a_cfg.window_level == `RMC_LEVEL_1V0);
	endproperty
	a_alt_a: assert property (p_alt_a)
		else $error("alt level a wrong");

	property p_alt_b;
		@(posedge clk) disable iff (!resetn)
		cmp_b_alt_level == (cmp_b_cfg.window_level == `RMC_LEVEL_1V0);
	endproperty
	a_alt_b: assert property (p_alt_b)
		else $error("alt level b wrong");

	////////////////////////////////////////////////////////////////////
	// rail enable routing
	property p_precharge;
		@(posedge clk) disable iff (!resetn)
		precharge_enable == (s_q.misc.precharge_enable_mask
			? regulator_enable_bit : precharge_enable_pin);
	endproperty
	a_precharge: assert property (p_precharge)
		else $error("precharge routing");

	property p_switched_on;
		@(posedge clk) disable iff (!resetn)
		s_q.misc.precharge_enable_override && !switched_3v3_pin_mask
			|-> switched_3v3_enable;
	endproperty
	a_switched_on: assert property (p_switched_on)
		else $error("switched override ignored");

	property p_switched_pin;
		@(posedge clk) disable iff (!resetn)
		!s_q.misc.precharge_enable_override
			|-> switched_3v3_enable == switched_3v3_pin;
	endproperty
	a_switched_pin: assert property (p_switched_pin)
		else $error("switched pin not followed");

	////////////////////////////////////////////////////////////////////
	// high fault bits: core pairs with mask bit 0, 1.05 V with bit 1
	property p_fault_core;
		@(posedge clk) disable iff (!resetn)
		!pg_low_in[1] && !s_q.fmask_hi[0] |=> power_fault[9];
	endproperty
	a_fault_core: assert property (p_fault_core)
		else $error("core fault lost");

	property p_fault_core_mask;
		@(posedge clk) disable iff (!resetn)
		s_q.fmask_hi[0] |=> !power_fault[9];
	endproperty
	a_fault_core_mask: assert property (p_fault_core_mask)
		else $error("masked core faulted");

	property p_fault_1v05;
		@(posedge clk) disable iff (!resetn)
		!pg_high_in[3] && !s_q.fmask_hi[1] |=> power_fault[8];
	endproperty
	a_fault_1v05: assert property (p_fault_1v05)
		else $error("1v05 fault lost");

	property p_fault_1v05_mask;
		@(posedge clk) disable iff (!resetn)
		s_q.fmask_hi[1] |=> !power_fault[8];
	endproperty
	a_fault_1v05_mask: assert property (p_fault_1v05_mask)
		else $error("masked 1v05 faulted");
endmodule

// ==== rmc_host_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// stand-in for the serial-bus front end: one byte per request at negedge
module rmc_host_model (
	input  wire logic         clk,
	output rmc_pkg::rmc_req_t req,
	input  wire logic [7:0]   rdata,
	input  wire logic         rvalid
);
	// strobes idle low from time zero
	initial req = '0;

	// released lines flip so a stale address is never mistaken for a new one
	task automatic release_bus();
		req.wr = 1'b0;
		req.rd = 1'b0;
		req.addr = ~req.addr;
		req.wdata = ~req.wdata;
	endtask

	// single write strobe, taken at the rising edge in between
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk);
		release_bus();
	endtask

	// single read strobe; the answer pulse stands during the next cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
			output logic ok);
		@(negedge clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk);
		ok = rvalid;
		d = rdata;
		release_bus();
	endtask
endmodule

// ==== test_rail_monitor_control_regs.sv ====
`timescale 1ns/1ps
module test_rail_monitor_control_regs;
	logic                  clk;
	logic                  resetn;
	rmc_pkg::rmc_req_t     req;
	logic [7:0]            rdata;
	logic                  rvalid;
	logic [7:0]            pg_lo;
	logic [4:0]            pg_hi;
	logic [8:0]            p;
	logic [6:0]            outs;
	rmc_pkg::rmc_cmp_ref_t cfg_a;
	rmc_pkg::rmc_cmp_ref_t cfg_b;
	logic                  alt_a;
	logic                  alt_b;
	logic [9:0]            fault;
	int                    failures;
	int                    check_count;
	int                    cycles;
	logic [7:0]            m;

	////////////////////////////////////////////////////////////////////////
	rmc_host_model u_host (.clk(clk), .req(req), .rdata(rdata),
		.rvalid(rvalid));
	rmc_regs u_dut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
		.rvalid(rvalid), .pg_low_in(pg_lo), .pg_high_in(pg_hi),
		.memory_termination_control_pin(p[0]), .switched_3v3_pin(p[1]),
		.switched_3v3_pin_mask(p[2]), .precharge_enable_pin(p[3]),
		.regulator_enable_bit(p[4]), .s3_sleep_signal(p[5]),
		.suspend_sleep_signal(p[6]), .adapter_ok_input(p[7]),
		.level_shifter_in(p[8]), .cmp_a_cfg(cfg_a), .cmp_b_cfg(cfg_b),
		.cmp_a_alt_level(alt_a), .cmp_b_alt_level(alt_b),
		.termination_enable(outs[6]), .switched_3v3_enable(outs[5]),
		.precharge_enable(outs[4]), .s3_sleep_tree_in(outs[3]),
		.suspend_sleep_tree_in(outs[2]), .level_shifter_out(outs[1]),
		.termination_discharge_enable(outs[0]), .power_fault(fault));

	////////////////////////////////////////////////////////////////////////
	// clock, and a hang guard well above the roughly 160 cycles needed
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		u_host.rd(a, d, ok);
		chk({ok, 1'b0, d}, {2'b10, e});
	endtask

	// fault bits: core, 1v05, then mask-low order; masks pair per rail
	function automatic logic [9:0] ef(logic [7:0] s, logic [4:0] h,
			logic [7:0] k, logic [1:0] kh);
		return ~{s[1], h[3], s[0], h[4], s[2], s[3], s[4], s[5], s[6], s[7]}
			& ~{kh[0], kh[1], k};
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({alt_a, alt_b, cfg_a}, {2'b00, 8'hb6});
		rchk(8'hdd, 8'hb6);
		rchk(8'hde, 8'h1b);
		rchk(8'he5, 8'h01);
		rchk(8'he6, 8'hfc);
		rchk(8'he7, 8'ha5);
		rchk(8'he8, 8'hf6);
		rchk(8'he9, 8'h02);
		rchk(8'h00, 8'h00);
		$display("test reset values done");
	endtask

	task automatic t_rw();
		u_host.wr(8'hdd, 8'h48);
		chk({alt_a, cfg_a}, {1'b1, 8'h48});
		u_host.wr(8'hde, 8'hff);
		chk({alt_b, cfg_b}, {1'b0, 8'hff});
		rchk(8'hdd, 8'h48);
		u_host.wr(8'he5, 8'hfe);
		rchk(8'he5, 8'hfe);
		u_host.wr(8'he6, 8'h03);
		rchk(8'he6, 8'hff);
		u_host.wr(8'he6, 8'h02);
		rchk(8'he6, 8'hfe);
		pg_lo = 8'h3c;
		u_host.wr(8'he7, 8'h00);
		rchk(8'he7, 8'h3c);
		$display("test read write done");
	endtask

	task automatic t_misc();
		for (int i = 0; i < 32; i++) begin
			m = 8'(i * 37 + 3);
			u_host.wr(8'he9, m);
			p = 9'(i * 149 + 5);
			@(negedge clk);
			chk({3'b0, outs}, {3'b0, m[6] ? m[7] : p[0], p[1] | (m[5] & ~p[2]),
				m[4] ? p[4] : p[3], p[5] | m[3], p[6] | m[2],
				m[1] ? p[7] : p[8], m[0]});
		end
		rchk(8'he9, m);
		$display("test misc controls done");
	endtask

	task automatic t_fault();
		u_host.wr(8'he5, 8'h00);
		pg_lo = 8'h5a;
		pg_hi = 5'h00;
		repeat (3) @(negedge clk);
		chk(fault, ef(pg_lo, pg_hi, 8'h00, 2'h2));
		u_host.wr(8'he5, 8'h96);
		repeat (3) @(negedge clk);
		chk(fault, ef(pg_lo, pg_hi, 8'h96, 2'h2));
		rchk(8'he7, 8'h5a);
		u_host.wr(8'he6, 8'h01);
		pg_lo = 8'h58;
		repeat (3) @(negedge clk);
		chk(fault, ef(pg_lo, pg_hi, 8'h96, 2'h1));
		$display("test fault masking done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		pg_lo = 8'ha5;
		pg_hi = 5'h16;
		p = '0;
		failures = 0;
		check_count = 0;
		cycles = 0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		t_reset();
		t_rw();
		t_misc();
		t_fault();
		end_sim();
	end
endmodule
